// [include/bcache_ctl_pkg.sv]
// Constants, types and helpers for the backup-cache interface control block
package bcache_ctl_pkg;

  // Internal register addresses and widths
  localparam logic [7:0] CTL_ADDR = 8'hA0;
  localparam int IPR_W = 32;
  localparam int CTL_USED_W = 6;

  // Cache access speed encodings and their cycle counts
  localparam logic [1:0] SPD_2CYC = 2'h0;
  localparam logic [1:0] SPD_3CYC = 2'h1;
  localparam logic [1:0] SPD_4CYC = 2'h2;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;

  // Data and check-bit layout
  localparam int DATA_W = 64;
  localparam int HALF_W = 32;
  localparam int CHK_W = 8;
  localparam int HAM_W = 7;
  localparam int PAR_LO_BIT = 0;
  localparam int PAR_HI_BIT = 7;
  localparam int TAG_W = 15;
  localparam int TAG_CTL_W = 3;

  // Control fields, ordered as bits 5 down to 0
  typedef struct packed {
    logic [1:0] cache_access_speed;
    logic forced_hit;
    logic write_ce_off;
    logic ecc_mode;
    logic backup_cache_on;
  } ctl_t;

  localparam ctl_t CTL_RESET = 6'h00;

  // Internal register access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [IPR_W-1:0] wdata;
  } ipr_req_t;

  // Cache reference request
  typedef struct packed {
    logic valid;
    logic write;
    logic block;
  } ref_req_t;

  // Tag store read data
  typedef struct packed {
    logic match;
    logic [TAG_W-1:0] tag;
    logic tag_par;
    logic [TAG_CTL_W-1:0] ctl;
    logic ctl_par;
  } tag_rd_t;

  typedef enum logic [1:0] {ST_IDLE, ST_PROBE, ST_RAM} bus_state_t;

  // Access time in CPU cycles for a speed code
  function automatic logic [2:0] speed_cycles(input logic [1:0] s);
    case (s)
      SPD_2CYC: return CYC_2;
      SPD_3CYC: return CYC_3;
      default: return CYC_4;
    endcase
  endfunction : speed_cycles

endpackage : bcache_ctl_pkg

// [rtl/access_timer.sv]
// Counts out one cache RAM or tag access of a programmed length
`timescale 1ns/100ps
module access_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic start_i,
  input wire logic [2:0] cycles_i,
  // Status
  output logic busy_o,
  output logic done_o
);
  import bcache_ctl_pkg::*;

  typedef struct packed {
    logic run;
    logic [2:0] left;
  } timer_t;

  timer_t cur;
  timer_t next;

  assign busy_o = cur.run;
  assign done_o = cur.run && (cur.left == 3'h0);

  // Load on start, count down while running
  always_comb begin
    next = cur;
    if (start_i) begin
      next.run = 1'b1;
      next.left = cycles_i - 3'h1;
    end else if (done_o) begin
      next.run = 1'b0;
    end else if (cur.run) begin
      next.left = cur.left - 3'h1;
    end
    if (reset_i) begin
      next = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    cur <= next;
  end

  three_cyc_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (start_i && cycles_i == CYC_3) |=> !done_o [*2] ##1 done_o)
    else $error("three-cycle access length wrong");

endmodule : access_timer

// [rtl/bcache_interface_control.sv]
// Backup-cache interface control register and reference sequencer
`timescale 1ns/100ps
module bcache_interface_control (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Internal register access
  input wire bcache_ctl_pkg::ipr_req_t IPR_I,
  output logic [31:0] IPR_RDATA_O,
  output logic IPR_ACK_O,
  input wire logic [31:0] DIAG_BITS_I,
  // Cache reference request
  input wire bcache_ctl_pkg::ref_req_t REF_I,
  output logic REF_READY_O,
  output logic REF_HIT_O,
  output logic REF_DONE_O,
  output logic CYCLE_REQ_O,
  // Tag store
  input wire bcache_ctl_pkg::tag_rd_t TAG_I,
  output logic TAG_PROBE_O,
  output logic TAG_ERR_O,
  // Data RAMs
  output logic RAM_CE_O,
  output logic RAM_WE_O,
  input wire logic [63:0] WR_DATA_I,
  output logic [7:0] WR_CHK_O,
  input wire logic [63:0] RD_DATA_I,
  input wire logic [7:0] RD_CHK_I,
  output logic DATA_ERR_O
);
  import bcache_ctl_pkg::*;

  typedef struct packed {
    ctl_t ctl;
    bus_state_t st;
    logic write;
    logic block;
    logic [IPR_W-1:0] rdata;
    logic ack;
    logic hit;
    logic tag_err;
    logic done;
  } ctl_state_t;

  ctl_state_t cur;
  ctl_state_t next;

  logic ctl_sel;
  logic t_start;
  logic t_busy;
  logic t_done;
  logic [2:0] t_cycles;
  logic take_ref;
  logic bypass_ref;
  logic probe_end;
  logic force_mode;
  logic tag_bad;
  logic ref_hit;
  logic chk_valid;

  // Register decode
  assign ctl_sel = IPR_I.addr == CTL_ADDR;

  // Reference steering
  assign take_ref = (cur.st == ST_IDLE) && REF_I.valid && cur.ctl.backup_cache_on;
  assign bypass_ref = (cur.st == ST_IDLE) && REF_I.valid
                   && !cur.ctl.backup_cache_on;
  assign probe_end = (cur.st == ST_PROBE) && t_done;

  // Forced hit needs the cache enable and a block transfer
  assign force_mode = cur.ctl.backup_cache_on && cur.ctl.forced_hit
                   && cur.block;

  // Tag and tag-control parity, even over each field
  assign tag_bad = ((^TAG_I.tag) != TAG_I.tag_par) || ((^TAG_I.ctl) != TAG_I.ctl_par);

  // Forced hit bypasses both compare and parity
  assign ref_hit = force_mode || (TAG_I.match && !tag_bad);

  // Timer start and length
  assign t_start = take_ref || (probe_end && ref_hit);
  assign t_cycles = speed_cycles(cur.ctl.cache_access_speed);
  assign chk_valid = (cur.st == ST_RAM) && t_done && !cur.write;

  // Next state
  always_comb begin
    next = cur;
    next.ack = 1'b0;
    next.hit = 1'b0;
    next.tag_err = 1'b0;
    next.done = 1'b0;
    // True values are stored as written
    if (ctl_sel && IPR_I.wr) begin
      next.ctl = ctl_t'(IPR_I.wdata[CTL_USED_W-1:0]);
    end
    // Readback is inverted, diagnostic bits fill the rest
    if (ctl_sel && IPR_I.rd) begin
      next.ack = 1'b1;
      next.rdata = ~{DIAG_BITS_I[IPR_W-1:CTL_USED_W], cur.ctl};
    end
    unique case (cur.st)
      ST_IDLE: begin
        if (take_ref) begin
          next.st = ST_PROBE;
          next.write = REF_I.write;
          next.block = REF_I.block;
        end
      end
      ST_PROBE: begin
        if (t_done) begin
          next.hit = ref_hit;
          next.tag_err = tag_bad && !force_mode;
          next.st = ref_hit ? ST_RAM : ST_IDLE;
        end
      end
      ST_RAM: begin
        if (t_done) begin
          next.done = 1'b1;
          next.st = ST_IDLE;
        end
      end
      default: next.st = ST_IDLE;
    endcase
    if (RESET_I) begin
      next = '0;
      next.ctl = CTL_RESET;
      next.st = ST_IDLE;
    end
  end

  always_ff @(posedge CLK_I) begin
    cur <= next;
  end

  // Shared access timer for probe and RAM phases; the RAM phase
  // reloads it in the last probe cycle, so busy stays high across
  // the hand-over and only done marks the end of each phase
  access_timer u_timer (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .start_i(t_start),
    .cycles_i(t_cycles),
    .busy_o(t_busy),
    .done_o(t_done)
  );

  // Check-bit generation and checking
  check_bits u_check (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ecc_mode_i(cur.ctl.ecc_mode),
    .wr_data_i(WR_DATA_I),
    .wr_chk_o(WR_CHK_O),
    .chk_valid_i(chk_valid),
    .rd_data_i(RD_DATA_I),
    .rd_chk_i(RD_CHK_I),
    .err_o(DATA_ERR_O)
  );

  // Register outputs
  assign IPR_RDATA_O = cur.rdata;
  assign IPR_ACK_O = cur.ack;

  // Reference outputs
  assign REF_READY_O = cur.st == ST_IDLE;
  assign REF_HIT_O = cur.hit;
  assign REF_DONE_O = cur.done;
  assign TAG_ERR_O = cur.tag_err;
  assign CYCLE_REQ_O = bypass_ref || (probe_end && !ref_hit);
  assign TAG_PROBE_O = cur.st == ST_PROBE;

  // RAM strobes, chip enable held off on writes in output-enable mode
  assign RAM_WE_O = (cur.st == ST_RAM) && cur.write;
  assign RAM_CE_O = (cur.st == ST_RAM)
                 && !(cur.write && cur.ctl.write_ce_off);

  // Checks

  spd_reset_a: assert property (
    @(posedge CLK_I)
    RESET_I |=> cur.ctl.cache_access_speed == SPD_2CYC)
    else $error("speed field not cleared by reset");

  probe_two_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (take_ref && cur.ctl.cache_access_speed == SPD_2CYC)
      |=> TAG_PROBE_O [*2] ##1 !TAG_PROBE_O)
    else $error("two-cycle probe length wrong");

  probe_four_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (take_ref && cur.ctl.cache_access_speed == SPD_4CYC)
      |=> TAG_PROBE_O [*4] ##1 !TAG_PROBE_O)
    else $error("four-cycle probe length wrong");

  forced_hit_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (probe_end && cur.ctl.backup_cache_on && cur.ctl.forced_hit && cur.block)
      |=> REF_HIT_O ##1 (RAM_CE_O || RAM_WE_O))
    else $error("forced hit did not hit");

  parity_quiet_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (probe_end && force_mode && tag_bad) |=> !TAG_ERR_O && REF_HIT_O)
    else $error("tag parity reported in forced-hit mode");

  enable_wins_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (REF_I.valid && REF_READY_O && cur.ctl.forced_hit && !cur.ctl.backup_cache_on)
      |=> !REF_HIT_O && !TAG_PROBE_O)
    else $error("forced hit acted with cache disabled");

  write_ce_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (probe_end && ref_hit && cur.write && cur.ctl.write_ce_off
      && !(ctl_sel && IPR_I.wr))
      |=> RAM_WE_O && !RAM_CE_O)
    else $error("chip enable driven on write in output-enable mode");

  bypass_req_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (REF_I.valid && REF_READY_O && !cur.ctl.backup_cache_on)
      |-> CYCLE_REQ_O ##1 (!TAG_PROBE_O && REF_READY_O))
    else $error("disabled cache probed or delayed request");

  inv_read_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (ctl_sel && IPR_I.rd) |=> IPR_ACK_O
      && IPR_RDATA_O[CTL_USED_W-1:0] == ~$past(cur.ctl))
    else $error("control readback not inverted");

  diag_read_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (ctl_sel && IPR_I.rd)
      |=> IPR_RDATA_O[IPR_W-1:CTL_USED_W] == ~$past(DIAG_BITS_I[IPR_W-1:CTL_USED_W]))
    else $error("diagnostic bits not inverted on readback");

  tag_err_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (probe_end && !force_mode && tag_bad)
      |=> TAG_ERR_O && !REF_HIT_O)
    else $error("tag parity fault not reported");

  ram_len_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (probe_end && ref_hit && cur.ctl.cache_access_speed == SPD_3CYC)
      |=> (RAM_WE_O || RAM_CE_O) [*3] ##1 REF_DONE_O)
    else $error("three-cycle RAM phase length wrong");

  miss_req_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (probe_end && !ref_hit)
      |-> CYCLE_REQ_O ##1 (REF_READY_O && !REF_HIT_O))
    else $error("miss did not request a cycle");

  ce_on_read_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (probe_end && ref_hit && !cur.write)
      |=> RAM_CE_O && !RAM_WE_O)
    else $error("chip enable missing on read");

  ctl_store_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    (ctl_sel && IPR_I.wr)
      |=> cur.ctl == ctl_t'($past(IPR_I.wdata[CTL_USED_W-1:0])))
    else $error("control write not stored as written");

  // Main scenarios
  forced_ref_c: cover property (
    @(posedge CLK_I) disable iff (RESET_I)
    probe_end && force_mode ##1 REF_HIT_O);

  miss_req_c: cover property (
    @(posedge CLK_I) disable iff (RESET_I)
    probe_end && !ref_hit && CYCLE_REQ_O);

  bypass_c: cover property (
    @(posedge CLK_I) disable iff (RESET_I)
    bypass_ref);

  hit_done_c: cover property (
    @(posedge CLK_I) disable iff (RESET_I)
    REF_HIT_O ##[1:5] REF_DONE_O);

  write_off_c: cover property (
    @(posedge CLK_I) disable iff (RESET_I)
    RAM_WE_O && !RAM_CE_O);

endmodule : bcache_interface_control

// [rtl/check_bits.sv]
// Generates and checks ECC or parity check bits on cache data
`timescale 1ns/100ps
module check_bits (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Mode
  input wire logic ecc_mode_i,
  // Write side
  input wire logic [63:0] wr_data_i,
  output logic [7:0] wr_chk_o,
  // Read side
  input wire logic chk_valid_i,
  input wire logic [63:0] rd_data_i,
  input wire logic [7:0] rd_chk_i,
  output logic err_o
);
  import bcache_ctl_pkg::*;

  typedef struct packed {
    logic [CHK_W-1:0] chk;
    logic err;
  } chk_state_t;

  chk_state_t cur;
  chk_state_t next;
  logic [CHK_W-1:0] rd_exp;
  logic rd_bad;

  // Hamming bits over position codes plus overall parity
  function automatic logic [CHK_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    logic [HAM_W-1:0] pos;
    c = 8'h00;
    for (int j = 0; j < DATA_W; j++) begin
      pos = HAM_W'(j + 1);
      for (int k = 0; k < HAM_W; k++) begin
        if (pos[k]) begin
          c[k] = c[k] ^ d[j];
        end
      end
    end
    c[CHK_W-1] = (^d) ^ (^c[HAM_W-1:0]);
    return c;
  endfunction : ecc_gen

  // One parity bit per longword
  function automatic logic [CHK_W-1:0] par_gen(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    c = 8'h00;
    c[PAR_LO_BIT] = ^d[HALF_W-1:0];
    c[PAR_HI_BIT] = ^d[DATA_W-1:HALF_W];
    return c;
  endfunction : par_gen

  // Expected read check bits and mismatch per mode
  always_comb begin
    rd_exp = ecc_mode_i ? ecc_gen(rd_data_i) : par_gen(rd_data_i);
    if (ecc_mode_i) begin
      rd_bad = rd_exp != rd_chk_i;
    end else begin
      rd_bad = (rd_exp[PAR_LO_BIT] != rd_chk_i[PAR_LO_BIT])
            || (rd_exp[PAR_HI_BIT] != rd_chk_i[PAR_HI_BIT]);
    end
  end

  // Registered write check bits and read error pulse
  always_comb begin
    next.chk = ecc_mode_i ? ecc_gen(wr_data_i) : par_gen(wr_data_i);
    next.err = chk_valid_i && rd_bad;
    if (reset_i) begin
      next = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    cur <= next;
  end

  assign wr_chk_o = cur.chk;
  assign err_o = cur.err;

  par_mode_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !ecc_mode_i |=> wr_chk_o[PAR_LO_BIT] == ^$past(wr_data_i[HALF_W-1:0])
                    && wr_chk_o[HAM_W-1:1] == 6'h00)
    else $error("parity-mode check bits wrong");

endmodule : check_bits

// [verification/sram_model.sv]
// Behavioural model of the backup-cache tag store and data RAMs
`timescale 1ns/100ps
module sram_model (
  // Clock
  input wire logic clk_i,
  // Device strobes
  input wire logic tag_probe_i,
  input wire logic ram_ce_i,
  input wire logic ram_we_i,
  input wire logic [63:0] wr_data_i,
  input wire logic [7:0] wr_chk_i,
  // Scenario controls
  input wire logic hit_i,
  input wire logic tag_bad_i,
  input wire logic flip_i,
  // Answers
  output bcache_ctl_pkg::tag_rd_t tag_o,
  output logic [63:0] rd_data_o,
  output logic [7:0] rd_chk_o
);
  import bcache_ctl_pkg::*;
  logic [63:0] mem_data = 64'h0;
  logic [7:0] mem_chk = 8'h00;
  logic toggle = 1'b0;
  localparam logic [14:0] TAG_VAL = 15'h2A5C;
  localparam logic [2:0] TCTL_VAL = 3'h5;
  // One stored word, captured on every write cycle
  always @(posedge clk_i) begin
    toggle <= ~toggle;
    if (ram_we_i) begin
      mem_data <= wr_data_i;
      mem_chk <= wr_chk_i;
    end
  end
  // Tag answer while probed, a changing pattern otherwise
  always_comb begin
    if (tag_probe_i) begin
      tag_o = {hit_i, TAG_VAL, ^TAG_VAL ^ tag_bad_i, TCTL_VAL, ^TCTL_VAL};
    end else begin
      tag_o = {21{toggle}};
    end
  end
  // Read data only while selected for a read; flip corrupts bit 0
  always_comb begin
    if (ram_ce_i && !ram_we_i) begin
      rd_data_o = mem_data ^ {63'h0, flip_i};
      rd_chk_o = mem_chk;
    end else begin
      rd_data_o = {64{toggle}};
      rd_chk_o = {8{toggle}};
    end
  end
endmodule : sram_model

// [verification/test_bcache_interface_control.sv]
// Self-checking bench for the backup-cache interface control block
`timescale 1ns/100ps
module test_bcache_interface_control;
  import bcache_ctl_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  ipr_req_t ipr = '0;
  ref_req_t rq = '0;
  logic [31:0] diag = 32'h0;
  logic [31:0] rdata;
  logic ack, ready, hit, done, creq, probe, tag_err, ce, we, data_err;
  tag_rd_t tag;
  logic [63:0] wdat = 64'h0;
  logic [63:0] rdat;
  logic [7:0] wchk;
  logic [7:0] rchk;
  logic m_hit = 1'b0;
  logic m_bad = 1'b0;
  logic m_flip = 1'b0;
  int mismatches = 0;
  int num_checks = 0;
  int n_probe, n_ce, n_we, n_busy, t_hit, t_done, t_req;
  logic s_terr, s_derr, ce_in_we;
  logic [31:0] r;
  logic a;
  logic [31:0] v;
  int n;

  // Clock
  always #5 clk = ~clk;

  bcache_interface_control DUT (.CLK_I(clk), .RESET_I(reset), .IPR_I(ipr),
    .IPR_RDATA_O(rdata), .IPR_ACK_O(ack), .DIAG_BITS_I(diag), .REF_I(rq),
    .REF_READY_O(ready), .REF_HIT_O(hit), .REF_DONE_O(done), .CYCLE_REQ_O(creq),
    .TAG_I(tag), .TAG_PROBE_O(probe), .TAG_ERR_O(tag_err), .RAM_CE_O(ce),
    .RAM_WE_O(we), .WR_DATA_I(wdat), .WR_CHK_O(wchk), .RD_DATA_I(rdat),
    .RD_CHK_I(rchk), .DATA_ERR_O(data_err));

  sram_model ram (.clk_i(clk), .tag_probe_i(probe), .ram_ce_i(ce), .ram_we_i(we),
    .wr_data_i(wdat), .wr_chk_i(wchk), .hit_i(m_hit), .tag_bad_i(m_bad),
    .flip_i(m_flip), .tag_o(tag), .rd_data_o(rdat), .rd_chk_o(rchk));

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // Compare and report
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  // Expected readback: everything inverted
  function automatic logic [31:0] exp_rd(input logic [31:0] d, input logic [5:0] c);
    return ~{d[31:6], c};
  endfunction : exp_rd

  // Register write, one-cycle strobe
  task automatic ipr_wr(input logic [7:0] ad, input logic [31:0] d);
    @(negedge clk);
    ipr = '{rd: 1'b0, wr: 1'b1, addr: ad, wdata: d};
    @(negedge clk);
    ipr.wr = 1'b0;
  endtask : ipr_wr

  // Register read, answer sampled one cycle after the strobe
  task automatic ipr_rd(input logic [7:0] ad, output logic [31:0] d, output logic k);
    @(negedge clk);
    ipr = '{rd: 1'b1, wr: 1'b0, addr: ad, wdata: 32'h0};
    @(negedge clk);
    ipr.rd = 1'b0;
    k = ack;
    d = rdata;
  endtask : ipr_rd

  // One reference, observed cycle by cycle until it ends
  task automatic do_ref(input logic w, input logic b);
    int end_k;
    end_k = 0;
    n_probe = 0;
    n_ce = 0;
    n_we = 0;
    n_busy = 0;
    t_hit = -1;
    t_done = -1;
    t_req = -1;
    {s_terr, s_derr, ce_in_we} = 3'h0;
    @(negedge clk);
    rq = '{valid: 1'b1, write: w, block: b};
    #1;
    if (creq === 1'b1) begin
      t_req = 0;
      end_k = -2;
    end
    for (int k = 1; k <= 24; k++) begin
      @(negedge clk);
      rq.valid = 1'b0;
      #1;
      n_probe += (probe === 1'b1);
      n_ce += (ce === 1'b1);
      n_we += (we === 1'b1);
      n_busy += (ready === 1'b0);
      if (we === 1'b1 && ce === 1'b1) ce_in_we = 1'b1;
      if (hit === 1'b1) t_hit = k;
      if (done === 1'b1) t_done = k;
      if (creq === 1'b1) t_req = k;
      if (tag_err === 1'b1) s_terr = 1'b1;
      if (data_err === 1'b1) s_derr = 1'b1;
      if (end_k == 0 && (done === 1'b1 || creq === 1'b1)) end_k = k;
      if (end_k != 0 && k >= end_k + 2) break;
    end
    if (end_k == 0) begin
      mismatches++;
      finish_test();
    end
  endtask : do_ref

  // Main sequence
  initial begin
    void'($urandom(48));
    repeat (16) @(negedge clk);
    reset = 1'b0;
    diag = $urandom();
    ipr_rd(CTL_ADDR, r, a);
    check(a, 1'b1);
    check(r, exp_rd(diag, 6'h00));
    ipr_rd(8'hA1, r, a);
    check(a, 1'b0);
    // Random contents, unmapped writes must not disturb them
    repeat (8) begin
      v = $urandom();
      if (v[5:4] == 2'h3) v[5:4] = SPD_4CYC;
      ipr_wr(CTL_ADDR, v);
      ipr_wr(8'h21, ~v);
      diag = $urandom();
      ipr_rd(CTL_ADDR, r, a);
      check(r, exp_rd(diag, v[5:0]));
    end
    // Complement, modify the speed field, write back
    ipr_rd(CTL_ADDR, r, a);
    v = ~r;
    v[5:4] = SPD_4CYC;
    ipr_wr(CTL_ADDR, v);
    ipr_rd(CTL_ADDR, r, a);
    check(r, exp_rd(diag, v[5:0]));
    // Reset in mid-run returns the control field to its reset value
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    ipr_rd(CTL_ADDR, r, a);
    check(r, exp_rd(diag, 6'h00));
    // Read hits at each speed
    m_hit = 1'b1;
    for (int s = 0; s < 3; s++) begin
      ipr_wr(CTL_ADDR, {26'h0, s[1:0], 3'h0, 1'b1});
      n = s + 2;
      do_ref(1'b0, 1'b1);
      check(n_probe, n);
      check(t_hit, n + 1);
      check(t_done, 2 * n + 1);
      check(n_ce, n);
      check(n_busy, 2 * n);
      check(ready, 1'b1);
      check(t_req, -1);
    end
    // Disabled, forced hit set: no probe, immediate request
    ipr_wr(CTL_ADDR, 32'h08);
    do_ref(1'b0, 1'b1);
    check(t_req, 0);
    check(n_probe, 0);
    check(n_busy, 0);
    check(t_hit, -1);
    // Forced hit on a miss with bad tag parity
    m_hit = 1'b0;
    m_bad = 1'b1;
    ipr_wr(CTL_ADDR, 32'h09);
    for (int w = 0; w < 2; w++) begin
      do_ref(w[0], 1'b1);
      check(t_hit, 3);
      check(s_terr, 1'b0);
    end
    // Non-block reference in forced-hit mode takes the normal compare
    do_ref(1'b0, 1'b0);
    check(t_req, 2);
    check(t_hit, -1);
    check(s_terr, 1'b1);
    // Normal mode: miss requests a cycle and reports the parity fault
    ipr_wr(CTL_ADDR, 32'h01);
    do_ref(1'b0, 1'b1);
    check(t_req, 2);
    check(t_hit, -1);
    check(s_terr, 1'b1);
    // Write then read back in parity and ECC modes
    m_bad = 1'b0;
    m_hit = 1'b1;
    for (int e = 0; e < 2; e++) begin
      ipr_wr(CTL_ADDR, {26'h0, 3'h0, ~e[0], e[0], 1'b1});
      wdat = {$urandom(), $urandom()};
      do_ref(1'b1, 1'b1);
      check(n_we, 2);
      check(ce_in_we, e[0]);
      if (e == 0) check(wchk, {^wdat[63:32], 6'h00, ^wdat[31:0]});
      do_ref(1'b0, 1'b1);
      check(s_derr, 1'b0);
      m_flip = 1'b1;
      do_ref(1'b0, 1'b1);
      check(s_derr, 1'b1);
      m_flip = 1'b0;
    end
    finish_test();
  end
endmodule : test_bcache_interface_control
